// ---- pkg/dds_pkg.sv ----
package dds_pkg;
    localparam int DDS_ACC_W = 28;
    localparam int DDS_PHASE_W = 12;
    localparam int DDS_AMP_W = 10;
    localparam int DDS_APB_AW = 8;
    localparam int DDS_FIFO_DEPTH = 16;

    localparam logic [7:0] DDS_OFS_TUNING_A = 8'h00;
    localparam logic [7:0] DDS_OFS_TUNING_B = 8'h04;
    localparam logic [7:0] DDS_OFS_OFFSET_A = 8'h08;
    localparam logic [7:0] DDS_OFS_OFFSET_B = 8'h0c;
    localparam logic [7:0] DDS_OFS_CONTROL = 8'h10;
    localparam logic [7:0] DDS_OFS_STATUS = 8'h14;
    localparam logic [7:0] DDS_OFS_ACCUM = 8'h18;

    localparam int DDS_CTL_W = 7;
    localparam int DDS_CTL_TUNING_SELECT_BIT = 0;
    localparam int DDS_CTL_OFFSET_SELECT_BIT = 1;
    localparam int DDS_CTL_PIN_CONTROL = 2;
    localparam int DDS_CTL_SOFT_RESET = 3;
    localparam int DDS_CTL_LOGIC_OUTPUT_ENABLE = 4;
    localparam int DDS_CTL_LOGIC_OUTPUT_SOURCE = 5;
    localparam int DDS_CTL_MODE = 6;

    localparam logic [6:0] DDS_CTL_RESET = 7'h00;
    localparam logic [27:0] DDS_TUNING_RESET = 28'h0000000;
    localparam logic [11:0] DDS_OFFSET_RESET = 12'h000;
    localparam logic [9:0] DDS_AMP_MIDSCALE = 10'h200;
    localparam logic [9:0] DDS_AMP_PEAK = 10'h1ff;
    localparam logic [11:0] DDS_HALF_SPAN = 12'h800;
endpackage : dds_pkg

// ---- hdl/dds_core.sv ----
// What this block does
// RULE_01: 28-bit phase accumulator wrapping modulo full range
// RULE_02: add active tuning word every clock the fifo is not full and no clear is active
// RULE_03: tuning word chosen by pin or bit
// RULE_04: switching tuning word keeps accumulator intact
// RULE_05: add one of two 12-bit offsets
// RULE_06: offset summed into accumulator top bits
// RULE_07: truncate phase to top 12 bits
// RULE_08: 12-bit phase drives parabolic sine approximation, 10-bit out
// RULE_09: enable and mode bits choose sine path
// RULE_10: offset chosen by pin or bit
// RULE_11: reset clears phase state, keeps registers
// RULE_12: pin held steady when bit selects
// RULE_13: logic output from msb or comparator
// RULE_14: all stages update on same edge
// RULE_15: offset sum wraps, never saturates
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dds_fifo #(
    parameter int WIDTH = dds_pkg::DDS_AMP_W,
    parameter int DEPTH = dds_pkg::DDS_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    import dds_pkg::*;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] count;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } dds_fifo_state_t;

    dds_fifo_state_t st;
    dds_fifo_state_t next_st;
    logic push;
    logic pop;

    // output stage is a register so the dac side sees flop outputs
    assign in_ready = (st.count != CW'(DEPTH));
    assign out_valid = st.out_valid;
    assign out_data = st.out_data;

    always_comb begin
        next_st = st;
        push = in_valid && in_ready;
        pop = (st.count != '0) && (!st.out_valid || out_ready);
        if (out_ready) begin
            next_st.out_valid = 1'b0;
        end
        if (pop) begin
            next_st.out_valid = 1'b1;
            next_st.out_data = st.mem[st.rptr];
            next_st.rptr = (st.rptr == PW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
        end
        if (push) begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = (st.wptr == PW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : dds_fifo

////////////////////////////////////////////////////////////////////////////////
module dds_core #(
    parameter int FIFO_DEPTH = dds_pkg::DDS_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [dds_pkg::DDS_APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tuning_select_pin,
    input wire logic offset_select_pin,
    input wire logic nco_reset_pin,
    input wire logic comparator_in,
    output logic logic_output,
    output logic dac_valid,
    output logic [dds_pkg::DDS_AMP_W-1:0] dac_data,
    input wire logic dac_ready
);
    import dds_pkg::*;

    typedef struct packed {
        logic [2:0] pin_meta;
        logic [2:0] pin_sync;
        logic cmp_meta;
        logic cmp_sync;
        logic [DDS_ACC_W-1:0] tuning_word_a;
        logic [DDS_ACC_W-1:0] tuning_word_b;
        logic [DDS_PHASE_W-1:0] phase_offset_a;
        logic [DDS_PHASE_W-1:0] phase_offset_b;
        logic [DDS_CTL_W-1:0] control;
        logic [DDS_ACC_W-1:0] acc;
        logic [DDS_PHASE_W-1:0] phase;
        logic phase_valid;
        logic [DDS_AMP_W-1:0] amp;
        logic amp_valid;
        logic logic_output;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dds_state_t;

    dds_state_t st;
    dds_state_t next_st;
    logic fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // parabolic half-wave shaping: a full 4096 entry table costs far more
    // area, the parabola stays within a few percent of a true sine
    function automatic logic [DDS_AMP_W-1:0] dds_sine(input logic [DDS_PHASE_W-1:0] p);
        logic [10:0] u;
        logic [11:0] w;
        logic [22:0] v;
        logic [9:0] a;
        u = p[10:0];
        w = DDS_HALF_SPAN - {1'b0, u};
        // widen both factors first so the product keeps all its bits
        v = 23'(u) * 23'(w);
        a = v[20:11];
        if (a > DDS_AMP_PEAK) begin
            a = DDS_AMP_PEAK;
        end
        dds_sine = p[11] ? (DDS_AMP_MIDSCALE - a) : (DDS_AMP_MIDSCALE + a);
    endfunction : dds_sine

    function automatic logic [DDS_AMP_W-1:0] dds_triangle(input logic [DDS_PHASE_W-1:0] p);
        dds_triangle = p[11] ? ~p[10:1] : p[10:1];
    endfunction : dds_triangle

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic pin_mode;
        logic use_b;
        logic off_b;
        logic nco_clear;
        logic advance;
        logic [DDS_ACC_W-1:0] tw;
        logic [DDS_PHASE_W-1:0] po;
        logic apb_access;
        pin_mode = 1'b0;
        use_b = 1'b0;
        off_b = 1'b0;
        nco_clear = 1'b0;
        advance = 1'b0;
        tw = '0;
        po = '0;
        apb_access = 1'b0;
        next_st = st;

        // two-stage synchronisers for pins from outside the clock domain
        next_st.pin_meta = {nco_reset_pin, offset_select_pin, tuning_select_pin};
        next_st.pin_sync = st.pin_meta;
        next_st.cmp_meta = comparator_in;
        next_st.cmp_sync = st.cmp_meta;

        // apb: answer prepared in the setup cycle, so access lasts one cycle
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            next_st.pready = 1'b1;
            next_st.prdata = '0;
            case (paddr)
                DDS_OFS_TUNING_A: next_st.prdata = 32'(st.tuning_word_a);
                DDS_OFS_TUNING_B: next_st.prdata = 32'(st.tuning_word_b);
                DDS_OFS_OFFSET_A: next_st.prdata = 32'(st.phase_offset_a);
                DDS_OFS_OFFSET_B: next_st.prdata = 32'(st.phase_offset_b);
                DDS_OFS_CONTROL: next_st.prdata = 32'(st.control);
                DDS_OFS_STATUS: next_st.prdata = 32'({st.phase, st.amp});
                DDS_OFS_ACCUM: next_st.prdata = 32'(st.acc);
                default: next_st.pslverr = 1'b1;
            endcase
        end
        apb_access = psel && penable && st.pready && pwrite && !st.pslverr;
        if (apb_access) begin
            case (paddr)
                DDS_OFS_TUNING_A: next_st.tuning_word_a = pwdata[DDS_ACC_W-1:0];
                DDS_OFS_TUNING_B: next_st.tuning_word_b = pwdata[DDS_ACC_W-1:0];
                DDS_OFS_OFFSET_A: next_st.phase_offset_a = pwdata[DDS_PHASE_W-1:0];
                DDS_OFS_OFFSET_B: next_st.phase_offset_b = pwdata[DDS_PHASE_W-1:0];
                DDS_OFS_CONTROL: next_st.control = pwdata[DDS_CTL_W-1:0];
                default: next_st.control = st.control;
            endcase
        end

        // source of both selects: synchronised pins or control bits
        pin_mode = st.control[DDS_CTL_PIN_CONTROL];
        use_b = pin_mode ? st.pin_sync[0] : st.control[DDS_CTL_TUNING_SELECT_BIT]; // RULE_03
        off_b = pin_mode ? st.pin_sync[1] : st.control[DDS_CTL_OFFSET_SELECT_BIT]; // RULE_10
        tw = use_b ? st.tuning_word_b : st.tuning_word_a;
        po = off_b ? st.phase_offset_b : st.phase_offset_a;

        // pin or soft reset zeroes only the phase path, registers stay
        nco_clear = st.pin_sync[2] || st.control[DDS_CTL_SOFT_RESET];
        // a full fifo stalls the whole pipeline so no sample is dropped
        advance = fifo_in_ready;

        if (nco_clear) begin
            next_st.acc = '0; // RULE_11
            next_st.phase = '0; // RULE_11
            next_st.phase_valid = 1'b0;
            next_st.amp = DDS_AMP_MIDSCALE; // RULE_11
            next_st.amp_valid = 1'b1;
        end else if (advance) begin
            // selecting the other word only changes the increment
            next_st.acc = st.acc + tw; // RULE_01 RULE_02 RULE_04 RULE_14
            next_st.phase = st.acc[DDS_ACC_W-1 -: DDS_PHASE_W] + po; // RULE_05 RULE_06 RULE_07 RULE_15
            next_st.phase_valid = 1'b1;
            next_st.amp_valid = st.phase_valid;
            // triangle bypasses the parabolic sine shaping only with the logic output off
            if (st.control[DDS_CTL_MODE] && !st.control[DDS_CTL_LOGIC_OUTPUT_ENABLE]) begin // RULE_09
                next_st.amp = dds_triangle(st.phase);
            end else begin
                next_st.amp = dds_sine(st.phase); // RULE_08 RULE_14
            end
        end

        if (st.control[DDS_CTL_LOGIC_OUTPUT_ENABLE]) begin // RULE_13
            next_st.logic_output = st.control[DDS_CTL_LOGIC_OUTPUT_SOURCE]
                ? st.cmp_sync : st.acc[DDS_ACC_W-1]; // RULE_13
        end else begin
            next_st.logic_output = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.control <= DDS_CTL_RESET;
            st.tuning_word_a <= DDS_TUNING_RESET;
            st.tuning_word_b <= DDS_TUNING_RESET;
            st.phase_offset_a <= DDS_OFFSET_RESET;
            st.phase_offset_b <= DDS_OFFSET_RESET;
            st.amp <= DDS_AMP_MIDSCALE;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    dds_fifo #(
        .WIDTH(DDS_AMP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(st.amp_valid),
        .in_data(st.amp),
        .in_ready(fifo_in_ready),
        .out_valid(dac_valid),
        .out_data(dac_data),
        .out_ready(dac_ready)
    );

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign logic_output = st.logic_output;
endmodule : dds_core

// ---- testbench/dds_dac_model.sv ----
`timescale 1ns/1ps
module dds_dac_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic dac_valid,
    input wire logic [dds_pkg::DDS_AMP_W-1:0] dac_data,
    input wire logic stall,
    output logic dac_ready,
    output logic [dds_pkg::DDS_AMP_W-1:0] last_word
);
    import dds_pkg::*;
    // one code per cycle; stall stands for a paused converter feed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dac_ready <= 1'b0;
            last_word <= DDS_AMP_MIDSCALE;
        end else begin
            dac_ready <= !stall;
            if (dac_valid && dac_ready) begin
                last_word <= dac_data;
            end
        end
    end
endmodule : dds_dac_model

// ---- testbench/dds_core_monitor.sv ----
`timescale 1ns/1ps
module dds_core_monitor import dds_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [dds_pkg::DDS_APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nco_reset_pin,
    input wire logic comparator_in,
    input wire logic logic_output,
    input wire logic dac_valid,
    input wire logic [dds_pkg::DDS_AMP_W-1:0] dac_data,
    input wire logic dac_ready
);
    logic [6:0] ctl;
    logic [5:0] clr_cnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // shadow of control, so output checks know the selected mode
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= DDS_CTL_RESET;
            clr_cnt <= 6'h00;
        end else begin
            if (psel && penable && pready && pwrite && paddr == DDS_OFS_CONTROL) begin
                ctl <= pwdata[6:0];
            end
            clr_cnt <= !(nco_reset_pin && dac_ready) ? 6'h00 :
                (clr_cnt < 6'd40) ? clr_cnt + 6'd1 : clr_cnt;
        end
    end
    // margin of six covers the two-flop pin synchroniser
    sequence s_comp_hi; (ctl[5:4] == 2'b11 && comparator_in) [*6]; endsequence
    sequence s_comp_lo; (ctl[5:4] == 2'b11 && !comparator_in) [*6]; endsequence
    AST_SETUP_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_DAC_HOLD: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_data))
        else $error("stalled sample changed");
    AST_LOGIC_GATED: assert property (!ctl[4] && !$past(ctl[4]) && !$past(ctl[4], 2) |-> !logic_output)
        else $error("logic output active while disabled");
    AST_COMP_HI: assert property (s_comp_hi |-> logic_output)
        else $error("comparator high not passed");
    AST_COMP_LO: assert property (s_comp_lo |-> !logic_output)
        else $error("comparator low not passed");
    AST_CLEAR_MIDSCALE: assert property (clr_cnt == 6'd40 |-> dac_valid && dac_data == DDS_AMP_MIDSCALE)
        else $error("cleared phase not midscale");
endmodule : dds_core_monitor
bind dds_core dds_core_monitor i_mon (.clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .pslverr, .nco_reset_pin, .comparator_in, .logic_output, .dac_valid, .dac_data,
    .dac_ready);

// ---- testbench/dds_nco_phase_to_sine_core_tb.sv ----
`timescale 1ns/1ps
module dds_nco_phase_to_sine_core_tb;
    import dds_pkg::*;
    typedef struct packed {
        logic [6:0] ctl;
        logic pin;
        logic comp;
        logic [11:0] oa;
        logic [11:0] ob;
    } dds_row_t;
    logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, stall, sel, err;
    logic tuning_select_pin, offset_select_pin, nco_reset_pin, comparator_in;
    logic logic_output, dac_valid, dac_ready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, rd2;
    logic [9:0] dac_data, last_word;
    logic [11:0] ph;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    dds_row_t rows [8] = '{'{7'h00, 1'b0, 1'b0, 12'h400, 12'hc00},
        '{7'h02, 1'b1, 1'b1, 12'h400, 12'hc00}, '{7'h04, 1'b1, 1'b0, 12'h800, 12'h123},
        '{7'h06, 1'b0, 1'b1, 12'h123, 12'h800}, '{7'h40, 1'b0, 1'b0, 12'h400, 12'h000},
        '{7'h50, 1'b0, 1'b1, 12'h400, 12'h000}, '{7'h30, 1'b0, 1'b1, 12'h9ff, 12'h000},
        '{7'h30, 1'b0, 1'b0, 12'h9ff, 12'h000}};
    dds_core #(.FIFO_DEPTH(DDS_FIFO_DEPTH)) i_dut (.clk_sys, .rst_b, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .tuning_select_pin, .offset_select_pin,
        .nco_reset_pin, .comparator_in, .logic_output, .dac_valid, .dac_data, .dac_ready);
    dds_dac_model i_sink (.clk_sys, .rst_b, .dac_valid, .dac_data, .stall, .dac_ready,
        .last_word);
    ////////////////////////////////////////
    function automatic logic [9:0] exp_amp(input logic [11:0] p, input logic tri_m);
        logic [21:0] prod;
        prod = {11'h0, p[10:0]} * (22'd2048 - {11'h0, p[10:0]});
        prod[20:11] = (prod[21:11] > 11'h1ff) ? 10'h1ff : prod[20:11];
        return tri_m ? (p[11] ? ~p[10:1] : p[10:1]) :
            (p[11] ? DDS_AMP_MIDSCALE - prod[20:11] : DDS_AMP_MIDSCALE + prod[20:11]);
    endfunction : exp_amp
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // request stands until pready is seen high at a rising edge
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk
    task automatic complete_run;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ceiling well above the roughly 500 cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, stall} = '0;
        {tuning_select_pin, offset_select_pin, nco_reset_pin, comparator_in} = '0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        apb(1'b0, DDS_OFS_STATUS, 32'h0);
        chk(rd, 32'h200);
        foreach (rows[i]) begin
            apb(1'b1, DDS_OFS_OFFSET_A, {20'h0, rows[i].oa});
            apb(1'b1, DDS_OFS_OFFSET_B, {20'h0, rows[i].ob});
            apb(1'b1, DDS_OFS_CONTROL, {25'h0, rows[i].ctl});
            tuning_select_pin <= rows[i].pin;
            offset_select_pin <= rows[i].pin;
            comparator_in <= rows[i].comp;
            repeat (8) @(posedge clk_sys);
            ph = (rows[i].ctl[2] ? rows[i].pin : rows[i].ctl[1]) ? rows[i].ob : rows[i].oa;
            apb(1'b0, DDS_OFS_STATUS, 32'h0);
            chk(rd, {10'h0, ph, exp_amp(ph, rows[i].ctl[6] && !rows[i].ctl[4])});
            chk({31'h0, logic_output}, {31'h0, rows[i].ctl[5:4] == 2'b11 && rows[i].comp});
            $display("row %0d done", i);
        end
        // two thirds of a cycle per step, so three steps wrap past full scale
        apb(1'b1, DDS_OFS_TUNING_A, 32'h0aaaaaab);
        apb(1'b1, DDS_OFS_TUNING_B, 32'h00000100);
        for (int k = 0; k < 5; k++) begin
            tuning_select_pin <= !k[0];
            stall <= (k == 4);
            apb(1'b1, DDS_OFS_CONTROL, {29'h0, k[1], 1'b0, k[0]});
            repeat (40) @(posedge clk_sys);
            apb(1'b0, DDS_OFS_ACCUM, 32'h0);
            rd2 = rd;
            apb(1'b0, DDS_OFS_ACCUM, 32'h0);
            sel = k[1] ? !k[0] : k[0];
            chk((rd - rd2) & 32'h0fffffff, (k == 4) ? 32'h0 :
                (((sel ? 32'h100 : 32'haaaaaab) * 32'd3) & 32'h0fffffff));
        end
        stall <= 1'b0;
        $display("tuning test done");
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        nco_reset_pin <= 1'b1;
        repeat (50) @(posedge clk_sys);
        apb(1'b0, DDS_OFS_ACCUM, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, DDS_OFS_TUNING_A, 32'h0);
        chk(rd, 32'h0aaaaaab);
        chk({22'h0, last_word}, {22'h0, DDS_AMP_MIDSCALE});
        nco_reset_pin <= 1'b0;
        $display("clear test done");
        complete_run();
    end
endmodule : dds_nco_phase_to_sine_core_tb
